// ---- src/clkpg_top.v ----
// Clock generator: mode decode, two multipliers, dividers and standby gating.
//
// How it works
// - Mode pins decode to modes 0, 2, 3
// - Mode 0: reference times four onto bus pin
// - Mode 2: reference times two onto bus pin
// - Mode 3: bus pin input, skip second multiplier
// - First multiplier ratios 1,2,3,4,6,8 from register, 1 to 4 in mode 0
// - Bus clock rising edge tracks pin edge
// - Dividers 1..1/12 make CPU, peripheral clocks
// - CPU and peripheral ratios set independently
// - Register holds standby pin enable, ratios
// - Three clocks: CPU, peripheral, bus
// - Clocks stop in standby, per-module gating
// - Standby control sequences switching and standby
`timescale 1ns/1ns
`include "clkpg_defines.vh"

module clkpg_top #(
  parameter NUM_MOD = 4,
  parameter CNT_W   = 16
) (
  // Clock and reset
  input  wire                        core_clk,
  input  wire                        rstn,
  // Mode pins
  input  wire                        clock_mode_pin_lo,
  input  wire                        clock_mode_pin_hi,
  // Crystal pins
  input  wire                        crystal_input_pin,
  output reg                         crystal_output_pin,
  // Bus clock pin, split
  input  wire                        bus_clock_pin_in,
  output reg                         bus_clock_pin_out,
  output reg                         bus_clock_pin_oe,
  // Frequency control register access
  input  wire                        freqCtlWrite,
  input  wire [`CLKPG_FCR_WIDTH-1:0] freqCtlWrData,
  output reg  [`CLKPG_FCR_WIDTH-1:0] frequency_control_register,
  // Power-down requests
  input  wire                        sleepReq,
  input  wire                        swStandbyReq,
  input  wire                        deepStandbyReq,
  input  wire [NUM_MOD-1:0]          moduleStandby,
  // Generated clocks
  output reg                         cpuClk,
  output reg                         periphClk,
  output reg  [NUM_MOD-1:0]          moduleClk,
  output reg                         busClk,
  // Status
  output reg  [1:0]                  clockMode,
  output reg                         modeValid,
  output wire                        pll1Locked,
  output wire                        pll2Locked,
  output reg  [3:0]                  standbyState
);

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier value of a first-multiplier code, zero when invalid
  function [3:0] mulOf;
    input [2:0] code;
    begin
      case (code)
        3'h0:    mulOf = 4'h1;
        3'h1:    mulOf = 4'h2;
        3'h2:    mulOf = 4'h3;
        3'h3:    mulOf = 4'h4;
        3'h4:    mulOf = 4'h6;
        3'h5:    mulOf = 4'h8;
        default: mulOf = 4'h0;
      endcase
    end
  endfunction

  // Division value of a divider code, zero when invalid
  function [3:0] divOf;
    input [3:0] code;
    begin
      case (code)
        4'h0:    divOf = 4'h1;
        4'h1:    divOf = 4'h2;
        4'h2:    divOf = 4'h3;
        4'h3:    divOf = 4'h4;
        4'h4:    divOf = 4'h6;
        4'h5:    divOf = 4'h8;
        4'h6:    divOf = 4'hc;
        default: divOf = 4'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second
  reg [1:0] modeLoSync_r;
  reg [1:0] modeHiSync_r;
  reg [1:0] xtalSync_r;
  reg [1:0] busPinSync_r;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      modeLoSync_r <= 2'h0;
      modeHiSync_r <= 2'h0;
      xtalSync_r   <= 2'h0;
      busPinSync_r <= 2'h0;
    end else begin
      modeLoSync_r <= {modeLoSync_r[0], clock_mode_pin_lo};
      modeHiSync_r <= {modeHiSync_r[0], clock_mode_pin_hi};
      xtalSync_r   <= {xtalSync_r[0], crystal_input_pin};
      busPinSync_r <= {busPinSync_r[0], bus_clock_pin_in};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture once after reset; later pin changes are ignored, which is
  // the safe reading of pins that must not move during operation
  reg [1:0] capCnt_r;   // Waits out the synchroniser latency
  reg       modeDone_r; // Mode has been taken
  wire      mode3;

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      capCnt_r   <= 2'h0;
      modeDone_r <= 1'b0;
      clockMode  <= `CLKPG_MODE0;
      modeValid  <= 1'b0;
    end else if (!modeDone_r) begin
      capCnt_r <= capCnt_r + 1'b1;
      if (capCnt_r == 2'h3) begin
        modeDone_r <= 1'b1;
        // Decode of the two pins; low-high combination is not a mode
        if (!modeHiSync_r[1] && !modeLoSync_r[1]) begin
          clockMode <= `CLKPG_MODE0;
          modeValid <= 1'b1;
        end else if (modeHiSync_r[1] && !modeLoSync_r[1]) begin
          clockMode <= `CLKPG_MODE2;
          modeValid <= 1'b1;
        end else if (modeHiSync_r[1] && modeLoSync_r[1]) begin
          clockMode <= `CLKPG_MODE3;
          modeValid <= 1'b1;
        end else begin
          modeValid <= 1'b0;
        end
      end
    end
  end

  assign mode3 = (clockMode == `CLKPG_MODE3);

  ////////////////////////////////////////////////////////////////////////////
  // Frequency control register; a field with an invalid code keeps its old
  // value, and each field is written on its own so ratios change independently
  wire [2:0] wrMul  = freqCtlWrData[`CLKPG_FCR_MUL_HI:`CLKPG_FCR_MUL_LO];
  wire [3:0] wrCdiv = freqCtlWrData[`CLKPG_FCR_CDIV_HI:`CLKPG_FCR_CDIV_LO];
  wire [3:0] wrPdiv = freqCtlWrData[`CLKPG_FCR_PDIV_HI:`CLKPG_FCR_PDIV_LO];
  wire       mulOk;
  wire       mulChange;

  // Mode 0 refuses the x6 and x8 codes
  assign mulOk = (mulOf(wrMul) != 4'h0) &&
                 (clockMode != `CLKPG_MODE0 || wrMul <= `CLKPG_MUL_MAX_MODE0);
  assign mulChange = freqCtlWrite && mulOk &&
                     (wrMul != frequency_control_register[`CLKPG_FCR_MUL_HI:`CLKPG_FCR_MUL_LO]);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frequency_control_register <= `CLKPG_FCR_RESET;
    end else if (freqCtlWrite) begin
      frequency_control_register[`CLKPG_FCR_STBY_OE_BIT] <=
        freqCtlWrData[`CLKPG_FCR_STBY_OE_BIT];
      if (mulOk) begin
        frequency_control_register[`CLKPG_FCR_MUL_HI:`CLKPG_FCR_MUL_LO] <= wrMul;
      end
      if (divOf(wrCdiv) != 4'h0) begin
        frequency_control_register[`CLKPG_FCR_CDIV_HI:`CLKPG_FCR_CDIV_LO] <= wrCdiv;
      end
      if (divOf(wrPdiv) != 4'h0) begin
        frequency_control_register[`CLKPG_FCR_PDIV_HI:`CLKPG_FCR_PDIV_LO] <= wrPdiv;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Second multiplier on the crystal reference, fixed by mode
  wire [3:0] pll2Ratio;
  wire       pll2Out;
  wire       pll1Ref;
  wire       pll1Out;

  assign pll2Ratio = (clockMode == `CLKPG_MODE2) ? `CLKPG_PLL2_MODE2 :
                     `CLKPG_PLL2_MODE0;

  clkpg_mult #(.CNT_W(CNT_W)) u_pll2 (
    .core_clk (core_clk),
    .rstn     (rstn),
    .refIn    (xtalSync_r[1] & modeValid & ~mode3),
    .ratio    (pll2Ratio),
    .clkOut_r (pll2Out),
    .locked_r (pll2Locked)
  );

  // Mode 3 bypasses the second multiplier and takes the pin clock
  assign pll1Ref = mode3 ? busPinSync_r[1] : pll2Out;

  clkpg_mult #(.CNT_W(CNT_W)) u_pll1 (
    .core_clk (core_clk),
    .rstn     (rstn),
    .refIn    (pll1Ref & modeValid),
    .ratio    (mulOf(frequency_control_register[`CLKPG_FCR_MUL_HI:`CLKPG_FCR_MUL_LO])),
    .clkOut_r (pll1Out),
    .locked_r (pll1Locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Standby controller: holds clocks while the first multiplier relocks and
  // while a sleep, software standby or deep standby request stands
  reg [3:0]  state_nxt;
  reg [15:0] swCnt_r;   // Hold-off counter for a ratio switch
  wire       anyStby;
  // Load value kept as an integer and cut to the counter width on purpose
  localparam integer SW_LOAD = `CLKPG_SWITCH_CYC - 1;

  assign anyStby = sleepReq | swStandbyReq | deepStandbyReq;

  always @* begin
    state_nxt = standbyState;
    case (standbyState)
      `CLKPG_ST_START:  if (modeDone_r && pll1Locked) state_nxt = `CLKPG_ST_RUN;
      `CLKPG_ST_RUN: begin
        if (mulChange) begin
          state_nxt = `CLKPG_ST_SWITCH;
        end else if (anyStby) begin
          state_nxt = `CLKPG_ST_STBY;
        end
      end
      `CLKPG_ST_SWITCH: if (swCnt_r == 16'h0000) state_nxt = `CLKPG_ST_START;
      `CLKPG_ST_STBY:   if (!anyStby) state_nxt = `CLKPG_ST_START;
      default:          state_nxt = `CLKPG_ST_START;
    endcase
  end

  // State and switch counter; leaving via START waits for relock
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      standbyState <= `CLKPG_ST_START;
      swCnt_r      <= 16'h0000;
    end else begin
      standbyState <= state_nxt;
      if (standbyState == `CLKPG_ST_RUN && mulChange) begin
        swCnt_r <= SW_LOAD[15:0];
      end else if (swCnt_r != 16'h0000) begin
        swCnt_r <= swCnt_r - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dividers on rising edges of the first multiplier output; index 0 is the
  // CPU clock, 1 the peripheral clock. A new ratio is taken at the next
  // multiplier rising edge, even mid-cycle, so a runt pulse can appear. Ratio three gives uneven duty.
  reg        pll1Prev_r;
  wire       pll1Rise = pll1Out & ~pll1Prev_r;
  reg  [3:0] divCnt_r [0:1];
  reg  [1:0] divClk_r;
  wire [3:0] divVal [0:1];

  assign divVal[0] = divOf(frequency_control_register[`CLKPG_FCR_CDIV_HI:`CLKPG_FCR_CDIV_LO]);
  assign divVal[1] = divOf(frequency_control_register[`CLKPG_FCR_PDIV_HI:`CLKPG_FCR_PDIV_LO]);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pll1Prev_r <= 1'b0;
    end else begin
      pll1Prev_r <= pll1Out;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_div
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          divCnt_r[gi] <= 4'h0;
          divClk_r[gi] <= 1'b0;
        end else if (divVal[gi] == 4'h1) begin
          // Ratio one passes the multiplier output straight on
          divCnt_r[gi] <= 4'h0;
          divClk_r[gi] <= pll1Out;
        end else if (pll1Rise) begin
          if (divCnt_r[gi] >= divVal[gi] - 4'h1) begin
            divCnt_r[gi] <= 4'h0;
            divClk_r[gi] <= 1'b1;
          end else begin
            divCnt_r[gi] <= divCnt_r[gi] + 4'h1;
            if (divCnt_r[gi] + 4'h1 == {1'b0, divVal[gi][3:1]}) begin
              divClk_r[gi] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Output gating: sleep stops the CPU clock only, the standby modes stop
  // all (software standby keeps the bus pin when its enable bit is set), module standby stops one peripheral branch
  wire running  = (standbyState == `CLKPG_ST_RUN);
  wire deepStop = swStandbyReq | deepStandbyReq;
  wire stbyOe   = frequency_control_register[`CLKPG_FCR_STBY_OE_BIT];

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cpuClk             <= 1'b0;
      periphClk          <= 1'b0;
      moduleClk          <= {NUM_MOD{1'b0}};
      busClk             <= 1'b0;
      bus_clock_pin_out  <= 1'b0;
      bus_clock_pin_oe   <= 1'b0;
      crystal_output_pin <= 1'b0;
    end else begin
      cpuClk    <= running & divClk_r[0];
      periphClk <= (running | (sleepReq & ~deepStop)) & divClk_r[1];
      moduleClk <= {NUM_MOD{(running | (sleepReq & ~deepStop)) & divClk_r[1]}} &
                   ~moduleStandby;
      busClk    <= (running | (sleepReq & ~deepStop)) & pll1Ref;
      // Oscillator drive is the inverted crystal input; idle in mode 3
      crystal_output_pin <= modeValid & ~mode3 & ~xtalSync_r[1];
      // Pin drives out in modes 0 and 2, input in mode 3
      bus_clock_pin_oe   <= modeValid & ~mode3;
      bus_clock_pin_out  <= modeValid & ~mode3 & pll2Out &
                            ~(deepStandbyReq | (swStandbyReq & ~stbyOe));
    end
  end

endmodule

// ---- src/clkpg_defines.vh ----
// Constants for the clock generator: frequency control layout, codes, reset and timing.
`ifndef CLKPG_DEFINES_VH
`define CLKPG_DEFINES_VH

// Core clock period
`define CLKPG_CLK_NS          4
// Clock hold-off after a multiplier change, in ns, and in core cycles (rounded down)
`define CLKPG_SWITCH_NS       1000
`define CLKPG_SWITCH_CYC      (`CLKPG_SWITCH_NS / `CLKPG_CLK_NS)

// Frequency control register layout
`define CLKPG_FCR_WIDTH       16
`define CLKPG_FCR_RESET       16'h1000
`define CLKPG_FCR_STBY_OE_BIT 12
`define CLKPG_FCR_MUL_HI      10
`define CLKPG_FCR_MUL_LO      8
`define CLKPG_FCR_CDIV_HI     7
`define CLKPG_FCR_CDIV_LO     4
`define CLKPG_FCR_PDIV_HI     3
`define CLKPG_FCR_PDIV_LO     0

// First multiplier codes: 0..5 give x1, x2, x3, x4, x6, x8
`define CLKPG_MUL_MAX_MODE0   3'h3

// Clock mode values reported on clockMode
`define CLKPG_MODE0           2'h0
`define CLKPG_MODE2           2'h2
`define CLKPG_MODE3           2'h3

// Second multiplier ratios per mode
`define CLKPG_PLL2_MODE0      4'h4
`define CLKPG_PLL2_MODE2      4'h2

// Standby controller one-hot states
`define CLKPG_ST_START        4'h1
`define CLKPG_ST_RUN          4'h2
`define CLKPG_ST_SWITCH       4'h4
`define CLKPG_ST_STBY         4'h8

`endif

// ---- src/clkpg_mult.v ----
// Digital frequency multiplier that locks its output phase to each reference rising edge.
`timescale 1ns/1ns
`include "clkpg_defines.vh"

module clkpg_mult #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // Reference and ratio
  input  wire             refIn,
  input  wire [3:0]       ratio,
  // Result
  output reg              clkOut_r,
  output reg              locked_r
);

  ////////////////////////////////////////////////////////////////////////////
  reg             refPrev_r;   // Reference one cycle ago
  reg             seenEdge_r;  // A first edge has been seen
  reg [CNT_W-1:0] periodCnt_r; // Cycles since last reference edge
  reg [CNT_W-1:0] period_r;    // Last measured reference period
  reg [CNT_W:0]   acc_r;       // Phase accumulator
  wire            refRise;
  wire [CNT_W:0]  accSum;

  assign refRise = refIn & ~refPrev_r;
  // Two toggles per output period, so step is twice the ratio
  assign accSum  = acc_r + {{(CNT_W-4){1'b0}}, ratio, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  // Period measure and accumulator; restart on each reference rise keeps
  // the output rising edge aligned to the reference rising edge
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      refPrev_r   <= 1'b0;
      seenEdge_r  <= 1'b0;
      periodCnt_r <= {CNT_W{1'b0}};
      period_r    <= {CNT_W{1'b0}};
      acc_r       <= {(CNT_W+1){1'b0}};
      clkOut_r    <= 1'b0;
      locked_r    <= 1'b0;
    end else begin
      refPrev_r <= refIn;
      if (refRise) begin
        // Realign the phase on every reference edge
        seenEdge_r  <= 1'b1;
        periodCnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
        period_r    <= periodCnt_r;
        acc_r       <= {(CNT_W+1){1'b0}};
        locked_r    <= seenEdge_r;
        clkOut_r    <= seenEdge_r;
      end else begin
        // Saturate so a stopped reference does not wrap
        if (periodCnt_r != {CNT_W{1'b1}}) begin
          periodCnt_r <= periodCnt_r + 1'b1;
        end
        if (locked_r && accSum >= {1'b0, period_r}) begin
          acc_r    <= accSum - {1'b0, period_r};
          clkOut_r <= ~clkOut_r;
        end else if (locked_r) begin
          acc_r <= accSum;
        end
      end
    end
  end

endmodule

// ---- verification/clkpg_checker.sv ----
// Concurrent checks on the clock generator top ports.
`timescale 1ns/1ns
`include "clkpg_defines.vh"

module clkpg_checker #(
  parameter NUM_MOD = 4
) (
  // Clock and reset
  input logic                        core_clk,
  input logic                        rstn,
  // Mode pins and pin direction
  input logic                        clock_mode_pin_lo,
  input logic                        clock_mode_pin_hi,
  input logic                        bus_clock_pin_oe,
  // Register access
  input logic                        freqCtlWrite,
  input logic [`CLKPG_FCR_WIDTH-1:0] freqCtlWrData,
  input logic [`CLKPG_FCR_WIDTH-1:0] frequency_control_register,
  // Power-down requests
  input logic                        sleepReq,
  input logic                        swStandbyReq,
  input logic                        deepStandbyReq,
  input logic [NUM_MOD-1:0]          moduleStandby,
  // Clocks and status
  input logic                        cpuClk,
  input logic                        periphClk,
  input logic                        busClk,
  input logic [NUM_MOD-1:0]          moduleClk,
  input logic [1:0]                  clockMode,
  input logic                        modeValid,
  input logic [3:0]                  standbyState
);
  ////////////////////////////////////////////////////////////////////////////////
  // Short aliases; mode 0 caps the multiplier code lower
  wire [15:0] fcr    = frequency_control_register;
  wire        quiet  = !sleepReq && !swStandbyReq && !deepStandbyReq;
  wire        inRun  = standbyState == `CLKPG_ST_RUN;
  wire        inStby = standbyState == `CLKPG_ST_STBY;
  wire        inSw   = standbyState == `CLKPG_ST_SWITCH;
  wire [2:0]  mulMax = (clockMode == `CLKPG_MODE0) ? `CLKPG_MUL_MAX_MODE0 : 3'h5;
  // Cycles after entry at which the hold-off is still standing, last one included
  localparam int HOLD_CYC = `CLKPG_SWITCH_CYC - 1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////////
  AST_MODE_DECODE: assert property (
    modeValid |-> clockMode == {clock_mode_pin_hi, clock_mode_pin_lo}) else $error("mode");
  AST_PIN_DIR: assert property (
    modeValid [*3] |-> bus_clock_pin_oe == (clockMode != `CLKPG_MODE3)) else $error("pin dir");
  AST_WR_BIT12: assert property (
    freqCtlWrite |=> fcr[12] == $past(freqCtlWrData[12])) else $error("standby pin bit");
  AST_MUL_RANGE: assert property (
    fcr[10:8] <= mulMax) else $error("mult code");
  AST_DIV_RANGE: assert property (
    fcr[7:4] <= 4'h6 && fcr[3:0] <= 4'h6) else $error("div code");
  AST_SW_ENTER: assert property (
    swStandbyReq && inRun |=> inStby) else $error("standby entry");
  AST_STBY_GATE: assert property (
    swStandbyReq && inStby |=> !cpuClk && !periphClk && !busClk) else $error("standby gate");
  AST_SLEEP_GATE: assert property (
    sleepReq [*3] |-> !cpuClk) else $error("sleep gate");
  AST_MOD_GATE: assert property (
    moduleStandby[1] [*3] |-> !moduleClk[1]) else $error("module gate");
  AST_SWITCH: assert property (
    freqCtlWrite && inRun && quiet && freqCtlWrData[10:8] != fcr[10:8]
    && freqCtlWrData[10:8] <= mulMax |=> inSw) else $error("switch entry");
  AST_HOLDOFF: assert property (
    $rose(inSw) |-> inSw [*8]) else $error("hold-off");
  AST_HOLDOFF_END: assert property (
    $rose(inSw) |-> ##HOLD_CYC inSw ##1 !inSw) else $error("hold-off length");

  // Main scenarios reached
  cover property (inStby);
  cover property (inSw);
  cover property (modeValid && clockMode == `CLKPG_MODE3);
endmodule

bind clkpg_top clkpg_checker #(.NUM_MOD(NUM_MOD)) i_clkpg_checker (
  .core_clk(core_clk), .rstn(rstn), .clock_mode_pin_lo(clock_mode_pin_lo),
  .clock_mode_pin_hi(clock_mode_pin_hi), .bus_clock_pin_oe(bus_clock_pin_oe),
  .freqCtlWrite(freqCtlWrite), .freqCtlWrData(freqCtlWrData),
  .frequency_control_register(frequency_control_register), .sleepReq(sleepReq),
  .swStandbyReq(swStandbyReq), .deepStandbyReq(deepStandbyReq),
  .moduleStandby(moduleStandby), .cpuClk(cpuClk), .periphClk(periphClk), .busClk(busClk),
  .moduleClk(moduleClk), .clockMode(clockMode), .modeValid(modeValid),
  .standbyState(standbyState)
);

// ---- verification/clkpg_source.sv ----
// Behavioural reference source: crystal, external oscillator or bus-pin clock.
`timescale 1ns/1ns

module clkpg_source #(
  parameter HALF_NS = 128, // Half period of the reference
  parameter PULL    = 1    // 1: line pulled up while stopped
) (
  // Control
  input  logic run,
  // Clock line
  output logic refClk
);
  // A stopped line shows the pull level or a changing pattern, whatever its last value
  initial begin
    refClk = 1'h0;
    forever begin
      if (run) begin
        #HALF_NS refClk = ~refClk;
      end else if (PULL) begin
        #4 refClk = 1'h1;
      end else begin
        #4 refClk = ~refClk;
      end
    end
  end
endmodule

// ---- verification/tb_top.sv ----
// Self-checking testbench for the clock generator.
`timescale 1ns/1ns
`include "clkpg_defines.vh"

module tb_top;
  // Design ports and bench state
  logic        core_clk, rstn, clock_mode_pin_lo, clock_mode_pin_hi, crystal_output_pin;
  logic        bus_clock_pin_out, bus_clock_pin_oe, freqCtlWrite, modeValid;
  logic        sleepReq, swStandbyReq, deepStandbyReq, cpuClk, periphClk, busClk;
  logic [15:0] freqCtlWrData, frequency_control_register;
  logic [3:0]  moduleStandby, moduleClk, standbyState;
  logic [1:0]  clockMode;
  logic        xtalClk, extClk, extRun, pll1Locked, pll2Locked;
  int          mismatches, n_compared, cnt[6];
  int          mval[6] = '{1, 2, 3, 4, 6, 8};
  // Pin level: the device drives it, or the outside source does
  wire         busPin = bus_clock_pin_oe ? bus_clock_pin_out : extClk;

  clkpg_top #(.NUM_MOD(4)) i_clkpg_top (
    .core_clk(core_clk), .rstn(rstn), .clock_mode_pin_lo(clock_mode_pin_lo),
    .clock_mode_pin_hi(clock_mode_pin_hi), .crystal_input_pin(xtalClk),
    .crystal_output_pin(crystal_output_pin), .bus_clock_pin_in(busPin),
    .bus_clock_pin_out(bus_clock_pin_out), .bus_clock_pin_oe(bus_clock_pin_oe),
    .freqCtlWrite(freqCtlWrite), .freqCtlWrData(freqCtlWrData),
    .frequency_control_register(frequency_control_register), .sleepReq(sleepReq),
    .swStandbyReq(swStandbyReq), .deepStandbyReq(deepStandbyReq),
    .moduleStandby(moduleStandby), .cpuClk(cpuClk), .periphClk(periphClk),
    .moduleClk(moduleClk), .busClk(busClk), .clockMode(clockMode), .modeValid(modeValid),
    .pll1Locked(pll1Locked), .pll2Locked(pll2Locked), .standbyState(standbyState));
  // Crystal is pulled up when unused; the pin source only runs in mode 3
  clkpg_source #(.HALF_NS(128), .PULL(1)) i_clkpg_source (.run(!extRun), .refClk(xtalClk));
  clkpg_source #(.HALF_NS(128), .PULL(0)) i_clkpg_source_ext (.run(extRun), .refClk(extClk));

  ////////////////////////////////////////////////////////////////////////////////
  // Compare helpers
  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input int k, exp, tol);
    n_compared++;
    if (cnt[k] < exp - tol || cnt[k] > exp + tol) begin
      mismatches++;
      $display("mismatch at %0t: clock %0d edges %0d exp %0d", $time, k, cnt[k], exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Rising edges of pin, bus, cpu, periph, module 0, module 1 over n cycles
  task automatic count(input int n);
    logic [5:0] p, v;
    p = '0;
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge core_clk);
      #1;
      v = {moduleClk[1:0], periphClk, cpuClk, busClk, busPin};
      for (int i = 0; i < 6; i++) if (v[i] && !p[i]) cnt[i]++;
      p = v;
    end
  endtask
  // Bounded wait for the run state; switching and relock take a few hundred cycles
  task automatic wait_run();
    int k;
    k = 0;
    while (standbyState !== `CLKPG_ST_RUN) begin
      @(posedge core_clk);
      #1;
      k++;
      if (k > 5000) begin
        mismatches++;
        $display("mismatch at %0t: run state not reached", $time);
        close_out();
      end
    end
    $display("step done at %0t", $time);
  endtask
  // Mode pins and source only change while reset is held
  task automatic restart(input logic hi, lo, ext);
    @(posedge core_clk);
    rstn <= 1'h0;
    clock_mode_pin_hi <= hi;
    clock_mode_pin_lo <= lo;
    extRun <= ext;
    repeat (20) @(posedge core_clk);
    #1;
    chk(frequency_control_register, 16'h1000);
    chk(standbyState, `CLKPG_ST_START);
    @(posedge core_clk);
    rstn <= 1'h1;
  endtask
  task automatic wr(input logic [15:0] d, exp);
    @(posedge core_clk);
    freqCtlWrite <= 1'h1;
    freqCtlWrData <= d;
    @(posedge core_clk);
    freqCtlWrite <= 1'h0;
    #1;
    chk(frequency_control_register, exp);
  endtask

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rstn, clock_mode_pin_hi, clock_mode_pin_lo, extRun, freqCtlWrite} = '0;
    {sleepReq, swStandbyReq, deepStandbyReq, freqCtlWrData, moduleStandby} = '0;
    mismatches = 0;
    n_compared = 0;
    // Mode 0: reference times four, driven out on the pin
    restart(1'h0, 1'h0, 1'h0);
    wait_run();
    chk({clockMode, modeValid, bus_clock_pin_oe}, 4'h3);
    chk({pll1Locked, pll2Locked}, 2'h3);
    count(384);
    near(0, 24, 1);
    near(1, 24, 1);
    wr(16'h1111, 16'h1111);
    wait_run();
    wr(16'h0471, 16'h0111);
    // Sleep, software standby, deep standby, each with module 1 stopped
    for (int s = 0; s < 3; s++) begin
      @(posedge core_clk);
      {deepStandbyReq, swStandbyReq, sleepReq} <= 3'h1 << s;
      moduleStandby <= 4'h2;
      repeat (4) @(posedge core_clk);
      if (s > 0) chk(standbyState, `CLKPG_ST_STBY);
      count(384);
      near(2, 0, 0);
      near(3, (s == 0) ? 24 : 0, 1);
      near(0, (s == 0) ? 24 : 0, 1);
      near(5, 0, 0);
      if (s == 0) chk(cnt[4] > 0, 1'h1);
      @(posedge core_clk);
      {deepStandbyReq, swStandbyReq, sleepReq} <= 3'h0;
      moduleStandby <= 4'h0;
      wait_run();
    end
    // Unused pin combination gives no mode
    restart(1'h0, 1'h1, 1'h0);
    repeat (20) @(posedge core_clk);
    #1;
    chk(modeValid, 1'h0);
    chk({pll1Locked, pll2Locked}, 2'h0);
    // Mode 2: reference times two; every multiplier, then divider codes 0 to 5
    restart(1'h1, 1'h0, 1'h0);
    wait_run();
    chk(clockMode, `CLKPG_MODE2);
    count(384);
    near(0, 12, 1);
    for (int m = 0; m < 6; m++) begin
      wr(16'h1000 | (m << 8), 16'h1000 | (m << 8));
      wait_run();
      count(384);
      near(2, 12 * mval[m], 2);
    end
    for (int k = 0; k < 6; k++) begin
      wr(16'h1510 | k, 16'h1510 | k);
      count(384);
      near(3, 96 / mval[k], 1);
      near(2, 48, 1);
    end
    // Mode 3: pin becomes an input and feeds the first multiplier
    restart(1'h1, 1'h1, 1'h1);
    wait_run();
    chk({clockMode, bus_clock_pin_oe, crystal_output_pin, pll2Locked}, 5'h18);
    wr(16'h1100, 16'h1100);
    wait_run();
    count(384);
    near(1, 6, 1);
    near(2, 12, 1);
    close_out();
  end
endmodule
